// ---- hw/hsc_config_bank.sv ----
/*
  Configuration words of the hall sensor: stored and active copies, reached by
  indirect 32-bit accesses through the direct 16-bit register port.
  Assumes the bus target logic presents one-cycle register read and write strobes
  and that conversion results arrive with a one-cycle valid strobe.
*/
`timescale 1ns/100ps
module hsc_config_bank #(
  parameter hsc_pkg::hsc_cnt_t IDLE_CYC [8] = hsc_pkg::IDLE_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic [14:0] field_sample_value_i,
  input  wire logic        sample_valid_i,
  input  wire logic [6:0]  bus_addr_i,
  input  wire logic        lp_pin_i,
  output logic             addr_match_o,
  output logic             status_b_o,
  output logic             pad_low_rail_o,
  output logic             smoothing_filter_enable_o,
  output logic      [1:0]  sense_mode_o,
  output logic             field_direction_sense_o,
  output logic      [1:0]  magnet_tempco_select_o,
  output logic      [1:0]  coarse_gain_select_o,
  output logic      [1:0]  zero_level_select_o,
  output logic      [2:0]  smoothing_bandwidth_select_o,
  output logic             fine_zero_doubling_o,
  output logic      [1:0]  sampling_mode_o,
  output logic             enter_sleep_o,
  output logic             enter_standby_o,
  output logic             duty_wake_o,
  output logic             osr_update_o
);

  typedef enum logic [0:0] {HSC_IDLE, HSC_BUSY} hsc_op_e;

  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic dir_hit(input logic [7:0] a, input logic [7:0] off);
    dir_hit = (a == off);
  endfunction

  // ************************************************
  // State
  // ************************************************
  logic [31:0] word_a_stored_q;
  logic [31:0] word_b_stored_q;
  logic [31:0] word_a_active_q;
  logic [31:0] word_b_active_q;
  logic [7:0]  wr_index_q;
  logic [31:0] wr_data_q;
  logic [7:0]  rd_index_q;
  logic [31:0] rd_data_q;
  hsc_op_e     wr_op_q;
  hsc_op_e     rd_op_q;
  logic [3:0]  wr_cnt_q;
  logic [3:0]  rd_cnt_q;
  logic        wr_busy_q;
  logic        wr_done_q;
  logic        rd_busy_q;
  logic        rd_done_q;
  logic [14:0] sample_q;
  logic        trip_flag_q;
  logic [15:0] rdata_q;
  logic        match_q;
  logic        sleep_q;
  logic        standby_q;
  hsc_pkg::hsc_cnt_t idle_cnt_q;
  logic        duty_wake_q;
  hsc_pkg::hsc_cnt_t osr_cnt_q;
  logic        osr_update_q;

  logic        wr_go;
  logic        rd_go;
  logic        wr_commit;
  logic        mag_read;
  logic        trip_set;
  logic [31:0] wr_masked;
  logic [15:0] rd_mux;
  hsc_pkg::hsc_cnt_t osr_limit;

  assign wr_go = reg_wr_i && dir_hit(reg_addr_i, hsc_pkg::DIR_WR_STATUS)
                 && reg_wdata_i[hsc_pkg::ST_TRIGGER_BIT];
  assign rd_go = reg_wr_i && dir_hit(reg_addr_i, hsc_pkg::DIR_RD_STATUS)
                 && reg_wdata_i[hsc_pkg::ST_TRIGGER_BIT];
  assign wr_commit = (wr_op_q == HSC_BUSY) && (wr_cnt_q == 4'h0);
  assign wr_masked = wr_data_q & hsc_pkg::WORD_WRITABLE_MASK;
  assign mag_read  = reg_rd_i && dir_hit(reg_addr_i, hsc_pkg::DIR_MAG_OUT);

  // ************************************************
  // Direct register writes
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_index_q <= 8'h00;
      wr_data_q  <= 32'h0000_0000;
      rd_index_q <= 8'h00;
    end else if (reg_wr_i) begin
      if (dir_hit(reg_addr_i, hsc_pkg::DIR_WR_ADDR)) begin
        wr_index_q <= reg_wdata_i[7:0];
      end
      if (dir_hit(reg_addr_i, hsc_pkg::DIR_WR_DATA_MSB)) begin
        wr_data_q[31:16] <= reg_wdata_i;
      end
      if (dir_hit(reg_addr_i, hsc_pkg::DIR_WR_DATA_LSB)) begin
        wr_data_q[15:0] <= reg_wdata_i;
      end
      if (dir_hit(reg_addr_i, hsc_pkg::DIR_RD_ADDR)) begin
        rd_index_q <= reg_wdata_i[7:0];
      end
    end
  end

  // ************************************************
  // Indirect write sequencer
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_op_q   <= HSC_IDLE;
      wr_cnt_q  <= 4'h0;
      wr_busy_q <= 1'b0;
      wr_done_q <= 1'b0;
    end else begin
      case (wr_op_q)
        HSC_IDLE: begin
          if (wr_go) begin
            wr_op_q   <= HSC_BUSY;
            wr_cnt_q  <= hsc_pkg::ACCESS_CYC - 4'h1;
            wr_busy_q <= 1'b1;
            wr_done_q <= 1'b0;
          end
        end
        HSC_BUSY: begin
          if (wr_cnt_q == 4'h0) begin
            wr_op_q   <= HSC_IDLE;
            wr_busy_q <= 1'b0;
            wr_done_q <= 1'b1;
          end else begin
            wr_cnt_q <= wr_cnt_q - 4'h1;
          end
        end
        default: begin
          wr_op_q <= HSC_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // Configuration words
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_a_stored_q <= hsc_pkg::WORD_A_RESET;
      word_b_stored_q <= hsc_pkg::WORD_B_RESET;
      word_a_active_q <= hsc_pkg::WORD_A_RESET;
      word_b_active_q <= hsc_pkg::WORD_B_RESET;
    end else if (wr_commit) begin
      case (wr_index_q)
        hsc_pkg::IDX_WORD_A_STORED: word_a_stored_q <= wr_masked;
        hsc_pkg::IDX_WORD_B_STORED: word_b_stored_q <= wr_masked;
        hsc_pkg::IDX_WORD_A_ACTIVE: word_a_active_q <= wr_masked;
        hsc_pkg::IDX_WORD_B_ACTIVE: word_b_active_q <= wr_masked;
        default: begin
        end
      endcase
    end
  end

  // ************************************************
  // Indirect read sequencer
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_op_q   <= HSC_IDLE;
      rd_cnt_q  <= 4'h0;
      rd_busy_q <= 1'b0;
      rd_done_q <= 1'b0;
      rd_data_q <= 32'h0000_0000;
    end else begin
      case (rd_op_q)
        HSC_IDLE: begin
          if (rd_go) begin
            rd_op_q   <= HSC_BUSY;
            rd_cnt_q  <= hsc_pkg::ACCESS_CYC - 4'h1;
            rd_busy_q <= 1'b1;
            rd_done_q <= 1'b0;
          end
        end
        HSC_BUSY: begin
          if (rd_cnt_q == 4'h0) begin
            rd_op_q   <= HSC_IDLE;
            rd_busy_q <= 1'b0;
            rd_done_q <= 1'b1;
            case (rd_index_q)
              hsc_pkg::IDX_WORD_A_STORED: rd_data_q <= word_a_stored_q;
              hsc_pkg::IDX_WORD_B_STORED: rd_data_q <= word_b_stored_q;
              hsc_pkg::IDX_WORD_A_ACTIVE: rd_data_q <= word_a_active_q;
              hsc_pkg::IDX_WORD_B_ACTIVE: rd_data_q <= word_b_active_q;
              default:                    rd_data_q <= 32'h0000_0000;
            endcase
          end else begin
            rd_cnt_q <= rd_cnt_q - 4'h1;
          end
        end
        default: begin
          rd_op_q <= HSC_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // Trip flag
  // ************************************************
  assign trip_set = sample_valid_i && word_b_active_q[hsc_pkg::B_TRIP_EN_BIT]
                    && (field_sample_value_i[14:9] >
                        word_b_active_q[hsc_pkg::B_TRIP_LVL_LSB +: 6]);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sample_q    <= 15'h0000;
      trip_flag_q <= 1'b0;
    end else begin
      if (sample_valid_i) begin
        sample_q <= field_sample_value_i;
      end
      if (trip_set) begin
        trip_flag_q <= 1'b1;
      end else if (mag_read) begin
        trip_flag_q <= 1'b0;
      end
    end
  end

  // ************************************************
  // Register read data
  // ************************************************
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr_i)
      hsc_pkg::DIR_WR_ADDR:     rd_mux = {8'h00, wr_index_q};
      hsc_pkg::DIR_WR_DATA_MSB: rd_mux = wr_data_q[31:16];
      hsc_pkg::DIR_WR_DATA_LSB: rd_mux = wr_data_q[15:0];
      hsc_pkg::DIR_WR_STATUS: begin
        rd_mux[hsc_pkg::ST_BUSY_BIT] = wr_busy_q;
        rd_mux[hsc_pkg::ST_DONE_BIT] = wr_done_q;
      end
      hsc_pkg::DIR_RD_ADDR:     rd_mux = {8'h00, rd_index_q};
      hsc_pkg::DIR_RD_STATUS: begin
        rd_mux[hsc_pkg::ST_BUSY_BIT] = rd_busy_q;
        rd_mux[hsc_pkg::ST_DONE_BIT] = rd_done_q;
      end
      hsc_pkg::DIR_RD_DATA_MSB: rd_mux = rd_data_q[31:16];
      hsc_pkg::DIR_RD_DATA_LSB: rd_mux = rd_data_q[15:0];
      hsc_pkg::DIR_MAG_OUT:     rd_mux = {trip_flag_q, sample_q};
      default:                  rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end
  end

  // ************************************************
  // Bus address match and low-power pin
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_q   <= 1'b0;
      sleep_q   <= 1'b0;
      standby_q <= 1'b0;
    end else begin
      match_q <= word_b_active_q[hsc_pkg::B_ANY_ADDR_BIT]
                 || (bus_addr_i == word_b_active_q[hsc_pkg::B_TGT_ADDR_LSB +: 7]);
      sleep_q   <= lp_pin_i && !word_b_active_q[hsc_pkg::B_LP_STANDBY_BIT];
      standby_q <= lp_pin_i && word_b_active_q[hsc_pkg::B_LP_STANDBY_BIT];
    end
  end

  // ************************************************
  // Duty-cycle idle timer
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_cnt_q  <= '0;
      duty_wake_q <= 1'b0;
    end else begin
      duty_wake_q <= 1'b0;
      if (word_b_active_q[hsc_pkg::B_SAMPLE_MODE_LSB +: 2] != hsc_pkg::MODE_DUTY
          || sleep_q || standby_q) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q >=
                   IDLE_CYC[word_b_active_q[hsc_pkg::B_IDLE_SEL_LSB +: 3]] - 27'h1) begin
        idle_cnt_q  <= '0;
        duty_wake_q <= 1'b1;
      end else begin
        idle_cnt_q <= idle_cnt_q + 27'h1;
      end
    end
  end

  // ************************************************
  // Oversample update timer
  // ************************************************
  assign osr_limit = word_b_active_q[hsc_pkg::B_OSR_LONG_BIT] ? hsc_pkg::OSR_LONG_CYC
                                                             : hsc_pkg::OSR_SHORT_CYC;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osr_cnt_q    <= '0;
      osr_update_q <= 1'b0;
    end else begin
      osr_update_q <= 1'b0;
      if (sleep_q || standby_q) begin
        osr_cnt_q <= '0;
      end else if (osr_cnt_q >= osr_limit - 27'h1) begin
        osr_cnt_q    <= '0;
        osr_update_q <= 1'b1;
      end else begin
        osr_cnt_q <= osr_cnt_q + 27'h1;
      end
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign reg_rdata_o                  = rdata_q;
  assign addr_match_o                 = match_q;
  assign status_b_o                   = !trip_flag_q;
  assign pad_low_rail_o               = word_a_active_q[hsc_pkg::A_PAD_RAIL_BIT];
  assign smoothing_filter_enable_o    = word_a_active_q[hsc_pkg::A_FILTER_EN_BIT];
  assign sense_mode_o                 = word_a_active_q[hsc_pkg::A_SENSE_MODE_LSB +: 2];
  assign field_direction_sense_o      = word_a_active_q[hsc_pkg::A_DIRECTION_BIT];
  assign magnet_tempco_select_o       = word_a_active_q[hsc_pkg::A_TEMPCO_LSB +: 2];
  assign coarse_gain_select_o         = word_a_active_q[hsc_pkg::A_GAIN_LSB +: 2];
  assign zero_level_select_o          = word_a_active_q[hsc_pkg::A_ZERO_LVL_LSB +: 2];
  assign smoothing_bandwidth_select_o = word_b_active_q[hsc_pkg::B_BANDWIDTH_LSB +: 3];
  assign fine_zero_doubling_o         = word_b_active_q[hsc_pkg::B_FINE_X2_BIT];
  assign sampling_mode_o              = word_b_active_q[hsc_pkg::B_SAMPLE_MODE_LSB +: 2];
  assign enter_sleep_o                = sleep_q;
  assign enter_standby_o              = standby_q;
  assign duty_wake_o                  = duty_wake_q;
  assign osr_update_o                 = osr_update_q;

endmodule

// ---- shared/hsc_pkg.sv ----
/*
  Constants, types and register layout of the hall sensor configuration bank.
  Assumes a 125 MHz system clock and the direct 16-bit register port of the device.
*/
// Behaviour
// - Bit 25 selects supply or low-voltage pad rail
// - Bit 24 switches the smoothing filter
// - Bits 20:19 select bipolar, unipolar or omnipolar
// - Bit 18 sets output rising field direction
// - Bits 17:16 select temperature coefficient
// - Bits 15:14 select coarse gain range
// - Bits 6:5 set bipolar zero level
// - Bandwidth selector maps eight filter corners
// - Bit 22 set accepts any bus address
// - Bits 21:15 hold the bus target address
// - Bit 14 enables threshold comparison
// - Trip when result top six bits exceed level
// - Bits 7:6 select continuous, one-shot, duty-cycled
// - Bit 5 picks sleep or standby for pin
// - Bits 4:2 select duty-cycle idle period
// - Bit 1 picks 40 or 80 cycle update
// - Write trigger sets busy, clears done, reads zero
// - Trip flag drives status pin, clears on read
package hsc_pkg;

  typedef logic [26:0] hsc_cnt_t;

  // ************************************************
  // Direct register offsets
  // ************************************************
  localparam logic [7:0] DIR_WR_ADDR     = 8'h02;
  localparam logic [7:0] DIR_WR_DATA_MSB = 8'h04;
  localparam logic [7:0] DIR_WR_DATA_LSB = 8'h06;
  localparam logic [7:0] DIR_WR_STATUS   = 8'h08;
  localparam logic [7:0] DIR_RD_ADDR     = 8'h0A;
  localparam logic [7:0] DIR_RD_STATUS   = 8'h0C;
  localparam logic [7:0] DIR_RD_DATA_MSB = 8'h0E;
  localparam logic [7:0] DIR_RD_DATA_LSB = 8'h10;
  localparam logic [7:0] DIR_MAG_OUT     = 8'h12;

  // Status bit positions
  localparam int unsigned ST_TRIGGER_BIT = 15;
  localparam int unsigned ST_BUSY_BIT    = 8;
  localparam int unsigned ST_DONE_BIT    = 0;
  localparam int unsigned MAG_FLAG_BIT   = 15;

  // ************************************************
  // Indirect word indices
  // ************************************************
  localparam logic [7:0] IDX_WORD_A_STORED = 8'h03;
  localparam logic [7:0] IDX_WORD_B_STORED = 8'h04;
  localparam logic [7:0] IDX_WORD_A_ACTIVE = 8'h23;
  localparam logic [7:0] IDX_WORD_B_ACTIVE = 8'h24;

  // Reserved bits 31:26 always zero
  localparam logic [31:0] WORD_WRITABLE_MASK = 32'h03FF_FFFF;
  localparam logic [31:0] WORD_A_RESET       = 32'h0000_0000;
  localparam logic [31:0] WORD_B_RESET       = 32'h0000_0000;

  // ************************************************
  // Word A field positions
  // ************************************************
  localparam int unsigned A_PAD_RAIL_BIT   = 25;
  localparam int unsigned A_FILTER_EN_BIT  = 24;
  localparam int unsigned A_SENSE_MODE_LSB = 19;
  localparam int unsigned A_DIRECTION_BIT  = 18;
  localparam int unsigned A_TEMPCO_LSB     = 16;
  localparam int unsigned A_GAIN_LSB       = 14;
  localparam int unsigned A_ZERO_LVL_LSB   = 5;

  // ************************************************
  // Word B field positions
  // ************************************************
  localparam int unsigned B_BANDWIDTH_LSB  = 23;
  localparam int unsigned B_ANY_ADDR_BIT   = 22;
  localparam int unsigned B_TGT_ADDR_LSB   = 15;
  localparam int unsigned B_TRIP_EN_BIT    = 14;
  localparam int unsigned B_TRIP_LVL_LSB   = 8;
  localparam int unsigned B_SAMPLE_MODE_LSB = 6;
  localparam int unsigned B_LP_STANDBY_BIT = 5;
  localparam int unsigned B_IDLE_SEL_LSB   = 2;
  localparam int unsigned B_OSR_LONG_BIT   = 1;
  localparam int unsigned B_FINE_X2_BIT    = 0;

  // Sampling mode codes
  localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] MODE_DUTY     = 2'h3;

  // ************************************************
  // Timing
  // ************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam hsc_cnt_t    OSR_SHORT_CYC = 27'h000_0028;
  localparam hsc_cnt_t    OSR_LONG_CYC  = 27'h000_0050;
  localparam logic [3:0]  ACCESS_CYC    = 4'h4;

  localparam int unsigned IDLE_NS_0 = 125000;
  localparam int unsigned IDLE_NS_1 = 250000;
  localparam int unsigned IDLE_NS_2 = 500000;
  localparam int unsigned IDLE_NS_3 = 1000000;
  localparam int unsigned IDLE_NS_4 = 10000000;
  localparam int unsigned IDLE_NS_5 = 100000000;
  localparam int unsigned IDLE_NS_6 = 500000000;
  localparam int unsigned IDLE_NS_7 = 1000000000;
  localparam hsc_cnt_t IDLE_CYC [8] = '{
    hsc_cnt_t'(IDLE_NS_0 / CLK_PERIOD_NS), hsc_cnt_t'(IDLE_NS_1 / CLK_PERIOD_NS),
    hsc_cnt_t'(IDLE_NS_2 / CLK_PERIOD_NS), hsc_cnt_t'(IDLE_NS_3 / CLK_PERIOD_NS),
    hsc_cnt_t'(IDLE_NS_4 / CLK_PERIOD_NS), hsc_cnt_t'(IDLE_NS_5 / CLK_PERIOD_NS),
    hsc_cnt_t'(IDLE_NS_6 / CLK_PERIOD_NS), hsc_cnt_t'(IDLE_NS_7 / CLK_PERIOD_NS)};

endpackage

// ---- verif/hsc_bank_checker.sv ----
/*
  Port checker of the config bank.
  Bound to every hsc_config_bank instance; sees only its ports.
*/
`timescale 1ns/100ps
module hsc_bank_checker (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        sample_valid_i,
  input wire logic        lp_pin_i,
  input wire logic        status_b_o,
  input wire logic [1:0]  sampling_mode_o,
  input wire logic        enter_sleep_o,
  input wire logic        enter_standby_o,
  input wire logic        duty_wake_o,
  input wire logic        osr_update_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ************************
  // Update gap counter
  // ************************
  logic [7:0] gap_q;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_q <= 8'h00;
    end else if (osr_update_o || lp_pin_i) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end
  // ************************
  // Sequences and assertions
  // ************************
  sequence s_wr_trigger;
    reg_wr_i && reg_addr_i == hsc_pkg::DIR_WR_STATUS && reg_wdata_i[15];
  endsequence
  sequence s_status_read;
    reg_rd_i && reg_addr_i == hsc_pkg::DIR_WR_STATUS;
  endsequence
  chk_trigger_reads_zero: assert property (s_status_read |=> !reg_rdata_o[15])
    else $error("trigger bit read back as one");
  chk_busy_after_trigger: assert property (s_wr_trigger ##1 s_status_read |=>
    reg_rdata_o[8] && !reg_rdata_o[0]) else $error("status not busy after trigger");
  chk_reserved_read_zero: assert property (reg_rd_i &&
    reg_addr_i == hsc_pkg::DIR_RD_DATA_MSB |=> reg_rdata_o[15:10] == 6'h00)
    else $error("reserved bits read nonzero");
  chk_trip_has_cause: assert property ($fell(status_b_o) |->
    $past(sample_valid_i) || $past(sample_valid_i, 2)) else $error("status fell without sample");
  chk_clear_has_cause: assert property ($rose(status_b_o) |->
    $past(reg_rd_i && reg_addr_i == hsc_pkg::DIR_MAG_OUT) ||
    $past(reg_rd_i && reg_addr_i == hsc_pkg::DIR_MAG_OUT, 2)) else $error("status rose without read");
  chk_lp_idle_none: assert property (!lp_pin_i [*2] |=> !enter_sleep_o && !enter_standby_o)
    else $error("low power entered without pin");
  chk_lp_one_mode: assert property (lp_pin_i [*2] |=> enter_sleep_o ^ enter_standby_o)
    else $error("pin did not pick exactly one mode");
  chk_osr_min_gap: assert property (osr_update_o |-> gap_q >= 8'h27)
    else $error("update pulses too close");
  chk_osr_max_gap: assert property (gap_q <= 8'h51)
    else $error("update pulse overdue");
  chk_duty_one_cycle: assert property (duty_wake_o |=> !duty_wake_o)
    else $error("wake pulse longer than one cycle");
  chk_duty_in_mode: assert property (duty_wake_o |-> sampling_mode_o == hsc_pkg::MODE_DUTY)
    else $error("wake pulse outside duty mode");
endmodule
bind hsc_config_bank hsc_bank_checker u_chk (.clock_i, .rst_b_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .sample_valid_i, .lp_pin_i, .status_b_o,
  .sampling_mode_o, .enter_sleep_o, .enter_standby_o, .duty_wake_o, .osr_update_o);

// ---- verif/hsc_config_bank_bench.sv ----
/*
  Self-checking testbench of the config bank.
  Host model drives the register port; sensor side is driven here at falling edges.
*/
`timescale 1ns/100ps
module hsc_config_bank_bench;
  localparam hsc_pkg::hsc_cnt_t IDLE_T [8] = '{27'h14, 27'h1E, 27'h28, 27'h32, 27'h3C,
    27'h46, 27'h50, 27'h5A};
  logic        clock_i = 1'b0;
  logic        rst_b_i, reg_wr_i, reg_rd_i, sample_valid_i, lp_pin_i, match_o, status_b_o;
  logic        pad_o, filt_o, dir_o, fine_o, slp_o, stb_o, wake_o, osr_o;
  logic [7:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, s0, s1, q;
  logic [14:0] field_sample_value_i;
  logic [6:0]  bus_addr_i;
  logic [31:0] w, r, n;
  logic [1:0]  sense_o, tc_o, gain_o, zero_o, mode_o;
  logic [2:0]  bw_o;
  int          err_total = 0;
  int          tests_run = 0;
  always #4 clock_i = ~clock_i;
  hsc_host_model host (.clock_i(clock_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
  hsc_config_bank #(.IDLE_CYC(IDLE_T)) uut (.clock_i, .rst_b_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .field_sample_value_i, .sample_valid_i,
    .bus_addr_i, .lp_pin_i, .addr_match_o(match_o),
    .status_b_o, .pad_low_rail_o(pad_o), .smoothing_filter_enable_o(filt_o),
    .sense_mode_o(sense_o), .field_direction_sense_o(dir_o), .magnet_tempco_select_o(tc_o),
    .coarse_gain_select_o(gain_o), .zero_level_select_o(zero_o),
    .smoothing_bandwidth_select_o(bw_o), .fine_zero_doubling_o(fine_o),
    .sampling_mode_o(mode_o), .enter_sleep_o(slp_o), .enter_standby_o(stb_o),
    .duty_wake_o(wake_o), .osr_update_o(osr_o));
  // ************************
  // Helpers
  // ************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic set_b(input logic [31:0] v);
    host.wr_word(hsc_pkg::IDX_WORD_B_ACTIVE, v, s0, s1);
  endtask
  task automatic feed(input logic [14:0] v);
    field_sample_value_i = v;
    sample_valid_i = 1'b1;
    @(negedge clock_i);
    sample_valid_i = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask
  task automatic gap_of(input logic duty, output logic [31:0] g);
    for (int i = 0; i < 300 && ((duty ? wake_o : osr_o) !== 1'b1); i++) @(negedge clock_i);
    g = 32'h1;
    @(negedge clock_i);
    while (((duty ? wake_o : osr_o) !== 1'b1) && g < 32'h12C) begin
      @(negedge clock_i);
      g++;
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock_i);
    err_total++;
    tally_and_finish();
  end
  // ************************
  // Tests
  // ************************
  initial begin
    rst_b_i = 1'b0;
    sample_valid_i = 1'b0;
    lp_pin_i = 1'b0;
    field_sample_value_i = 15'h0000;
    bus_addr_i = 7'h00;
    repeat (8) @(negedge clock_i);
    rst_b_i = 1'b1;
    chk("status pin", 32'h1, status_b_o);
    for (int k = 0; k < 4; k++) begin
      w = {6'h00, k[0], k[1], 3'h0, k[1:0], k[1], k[1:0], k[1:0], 7'h00, k[1:0], 5'h00};
      host.wr_word(hsc_pkg::IDX_WORD_A_ACTIVE, w, s0, s1);
      chk("busy", 32'h0100, s0);
      chk("done", 32'h0001, s1);
      host.rd_word(hsc_pkg::IDX_WORD_A_ACTIVE, r);
      chk("word a", w, r);
      chk("pad rail", w[25], pad_o);
      chk("filter", w[24], filt_o);
      chk("sense", w[20:19], sense_o);
      chk("direction", w[18], dir_o);
      chk("tempco", w[17:16], tc_o);
      chk("gain", w[15:14], gain_o);
      chk("zero", w[6:5], zero_o);
    end
    host.wr_word(hsc_pkg::IDX_WORD_A_STORED, 32'h0000_0000, s0, s1);
    host.rd_word(hsc_pkg::IDX_WORD_A_STORED, r);
    chk("stored a", 32'h0, r);
    chk("pad kept", 32'h1, pad_o);
    for (int k = 0; k < 8; k++) begin
      w = {6'h00, k[2:0], 1'b0, 7'h2A, 1'b0, 6'h00, k[1:0], k[2], k[2:0], k[0], 1'b0};
      set_b(w);
      host.rd_word(hsc_pkg::IDX_WORD_B_ACTIVE, r);
      chk("word b", w, r);
      chk("bandwidth", w[25:23], bw_o);
      chk("mode", w[7:6], mode_o);
      chk("fine", w[0], fine_o);
    end
    bus_addr_i = 7'h2A;
    repeat (2) @(negedge clock_i);
    chk("match", 32'h1, match_o);
    bus_addr_i = 7'h55;
    repeat (2) @(negedge clock_i);
    chk("no match", 32'h0, match_o);
    set_b(32'h0055_0000);
    chk("any addr", 32'h1, match_o);
    for (int k = 0; k < 2; k++) begin
      set_b(k ? 32'h0000_00DE : 32'h0000_00C0);
      gap_of(1'b1, n);
      chk("idle gap", k ? IDLE_T[7] : IDLE_T[0], n);
      gap_of(1'b0, n);
      chk("osr gap", k ? 32'h50 : 32'h28, n);
    end
    lp_pin_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk("sleep", 32'h1, {stb_o, slp_o});
    n = 32'h0;
    repeat (100) @(negedge clock_i) n += osr_o;
    chk("osr stop", 32'h0, n);
    lp_pin_i = 1'b0;
    set_b(32'h0000_00FE);
    lp_pin_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk("standby", 32'h2, {stb_o, slp_o});
    lp_pin_i = 1'b0;
    set_b(32'h0000_6000);
    feed(15'h41FF);
    chk("no trip", 32'h1, status_b_o);
    feed(15'h4200);
    chk("trip", 32'h0, status_b_o);
    host.rd_reg(hsc_pkg::DIR_MAG_OUT, q);
    host.idle();
    chk("mag flag", 32'hC200, q);
    @(negedge clock_i);
    chk("cleared", 32'h1, status_b_o);
    set_b(32'h0000_2000);
    feed(15'h7FFF);
    chk("trip off", 32'h1, status_b_o);
    host.rd_reg(hsc_pkg::DIR_MAG_OUT, q);
    host.idle();
    chk("mag value", 32'h7FFF, q);
    tally_and_finish();
  end
endmodule

// ---- verif/hsc_host_model.sv ----
/*
  Bus host model: register port accesses and indirect word transfers.
  Tasks are entered at a falling edge; strobes stay up until the next access or idle.
*/
`timescale 1ns/100ps
module hsc_host_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [7:0]  reg_addr_o,
  output logic      [15:0] reg_wdata_o
);
  initial begin
    idle_set();
  end
  function automatic void idle_set();
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
  endfunction
  task automatic idle();
    idle_set();
    @(negedge clock_i);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    reg_wr_o = 1'b1;
    reg_rd_o = 1'b0;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clock_i);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] q);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(negedge clock_i);
    q = reg_rdata_i;
  endtask
  task automatic poll(input logic [7:0] a, output logic [15:0] st);
    for (int i = 0; i < 16; i++) begin
      rd_reg(a, st);
      if (st[0] === 1'b1) break;
    end
    idle();
  endtask
  task automatic wr_word(input logic [7:0] idx, input logic [31:0] w,
                         output logic [15:0] busy_st, output logic [15:0] done_st);
    wr_reg(hsc_pkg::DIR_WR_ADDR, {8'h00, idx});
    wr_reg(hsc_pkg::DIR_WR_DATA_MSB, w[31:16]);
    wr_reg(hsc_pkg::DIR_WR_DATA_LSB, w[15:0]);
    wr_reg(hsc_pkg::DIR_WR_STATUS, 16'h8000);
    rd_reg(hsc_pkg::DIR_WR_STATUS, busy_st);
    poll(hsc_pkg::DIR_WR_STATUS, done_st);
  endtask
  task automatic rd_word(input logic [7:0] idx, output logic [31:0] w);
    logic [15:0] st;
    wr_reg(hsc_pkg::DIR_RD_ADDR, {8'h00, idx});
    wr_reg(hsc_pkg::DIR_RD_STATUS, 16'h8000);
    poll(hsc_pkg::DIR_RD_STATUS, st);
    rd_reg(hsc_pkg::DIR_RD_DATA_MSB, w[31:16]);
    rd_reg(hsc_pkg::DIR_RD_DATA_LSB, w[15:0]);
    idle();
  endtask
endmodule
